//--- verilog/pmmo_map.svh
// address map constants for the program memory overlay block
`ifndef PMMO_MAP_SVH
`define PMMO_MAP_SVH
`define PMMO_SPACE_TOP 16'hffff
`define PMMO_OPT_BASE 16'h0000
`define PMMO_RST_VEC 16'h0002
`define PMMO_WDT_VEC 16'h0004
`define PMMO_TRAP_VEC 16'h0006
`define PMMO_IRQ_VEC_LO 16'h0008
`define PMMO_IRQ_VEC_HI 16'h0037
`define PMMO_CODE_BASE 16'h0038
`define PMMO_INFO_BASE 16'hfe00
`define PMMO_PARTID_LO 9'h040
`define PMMO_PARTID_HI 9'h053
`define PMMO_OVL_EN_BIT 7
`define PMMO_BLANK_BYTE 8'hff
`define PMMO_FLASH_TOP_DEF 16'hffff
`endif

//--- verilog/pmmo_pkg.sv
// types for the program memory overlay block
package pmmo_pkg;
  typedef enum logic [1:0] {
    pmmo_src_fetch,
    pmmo_src_load,
    pmmo_src_dbg
  } pmmo_src_t;

  typedef struct packed {
    logic valid;
    logic wr;
    pmmo_src_t src;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pmmo_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } pmmo_rsp_t;

  typedef enum logic [1:0] {
    pmmo_region_vec,
    pmmo_region_code,
    pmmo_region_info,
    pmmo_region_blank
  } pmmo_region_t;
endpackage : pmmo_pkg

//--- verilog/pmmo_info_rom.sv
// read-only information area contents, part id and reserved bytes
`include "pmmo_map.svh"
module pmmo_info_rom
  import pmmo_pkg::*;
#(
  parameter logic [159:0] PART_ID = {"PARTID-0000", 72'h0}
) (
  input wire logic [8:0] idx,
  output logic [7:0] data
);
  logic [8:0] off;

  // part id sits left-justified, first char in the top byte of PART_ID
  always_comb begin
    off = idx - `PMMO_PARTID_LO;
    if (idx >= `PMMO_PARTID_LO && idx <= `PMMO_PARTID_HI) begin // RULE13
      data = PART_ID[8'(159 - 8 * off) -: 8];
    end else begin
      // reserved locations read as erased
      data = `PMMO_BLANK_BYTE;
    end
  end
endmodule : pmmo_info_rom

//--- verilog/pmmo_decoder.sv
// program memory decoder with information area overlay
//
// Functional notes
// [RULE1] decode the full 16-bit, 64KB program space for every variant
// [RULE2] flash spans zero to a per-variant top, 16KB up to 64KB
// [RULE3] reads above implemented flash return ff
// [RULE4] writes above implemented flash are dropped, nothing changes
// [RULE5] low 56 bytes hold option bits, reset, watchdog, trap, irq vectors
// [RULE6] the separate data memory space has no storage, nothing answers
// [RULE7] info area reachable only while page select bit 7 is set
// [RULE8] overlay covers fe00 through ffff when enabled
// [RULE9] both program space loads return info bytes in overlaid range
// [RULE10] debugger reads in overlaid range return info bytes too
// [RULE11] instruction fetches always read flash, overlay ignored; fetches above FLASH_TOP get ff with no flash read
// [RULE12] info area is read only, writes never alter it
// [RULE13] fe40 to fe53 hold a 20 char null padded part id
// [RULE14] with overlay off, fe00 to ffff come from flash or read ff
`include "pmmo_map.svh"
module pmmo_decoder
  import pmmo_pkg::*;
#(
  parameter logic [15:0] FLASH_TOP = `PMMO_FLASH_TOP_DEF,
  parameter logic [159:0] PART_ID = {"PARTID-0000", 72'h0}
) (
  input wire logic mclk,
  input wire logic rst,
  input wire pmmo_req_t req,
  input wire logic [7:0] page_sel,
  input wire logic data_space_req,
  input wire logic [7:0] flash_rdata,
  output pmmo_rsp_t rsp_ff,
  output logic data_space_ack_ff,
  output logic [15:0] flash_addr_ff,
  output logic flash_rd_ff,
  output logic flash_wr_ff,
  output logic [7:0] flash_wdata_ff,
  output pmmo_region_t region_ff
);
  logic in_flash;
  logic in_overlay;
  logic in_vec;
  logic ovl_en;
  logic use_info;

  logic is_rd;
  logic is_wr;
  logic rd_info;
  logic rd_blank;
  logic rd_flash;
  logic wr_flash;

  logic [7:0] info_byte;
  logic info_pend_ff;
  logic blank_pend_ff;
  logic flash_pend_ff;
  logic [7:0] info_hold_ff;
  logic [7:0] nxt_rdata;
  pmmo_region_t nxt_region;

  // 16-bit compare covers the whole space whatever the variant
  assign in_flash = req.addr <= FLASH_TOP; // RULE1 RULE2
  assign in_vec = req.addr < `PMMO_CODE_BASE; // RULE5
  assign ovl_en = page_sel[`PMMO_OVL_EN_BIT]; // RULE7
  assign in_overlay = req.addr >= `PMMO_INFO_BASE; // RULE8
  // fetches bypass the overlay; only loads and debugger reads see it
  assign use_info = ovl_en && in_overlay && !req.wr
                    && (req.src != pmmo_src_fetch); // RULE9 RULE10 RULE11

  // access classes; exactly one read class is set per valid read
  assign is_rd = req.valid && !req.wr;
  assign is_wr = req.valid && req.wr;
  assign rd_info = is_rd && use_info;
  assign rd_blank = is_rd && !use_info && !in_flash; // RULE3 RULE14
  assign rd_flash = is_rd && !use_info && in_flash;
  // overlay state does not redirect writes; info area stays intact
  assign wr_flash = is_wr && in_flash; // RULE4 RULE12 RULE14

  pmmo_info_rom #(
    .PART_ID(PART_ID)
  ) u_rom (
    .idx(req.addr[8:0]),
    .data(info_byte)
  );

  // region classification, kept for observation of the decode
  always_comb begin
    if (use_info) begin
      nxt_region = pmmo_region_info;
    end else if (!in_flash) begin
      nxt_region = pmmo_region_blank;
    end else if (in_vec) begin
      nxt_region = pmmo_region_vec; // RULE5
    end else begin
      nxt_region = pmmo_region_code;
    end
  end

  // read strobe to the array, one cycle per access
  always_ff @(posedge mclk) begin
    if (rst) begin
      flash_rd_ff <= 1'b0;
    end else begin
      flash_rd_ff <= rd_flash; // RULE11
    end
  end

  // write strobe; unimplemented space never sees one
  always_ff @(posedge mclk) begin
    if (rst) begin
      flash_wr_ff <= 1'b0;
    end else begin
      flash_wr_ff <= wr_flash; // RULE4
    end
  end

  // address held until the next in-range access
  always_ff @(posedge mclk) begin
    if (rst) begin
      flash_addr_ff <= 16'h0;
    end else if (req.valid && in_flash) begin
      flash_addr_ff <= req.addr;
    end
  end

  // write data follows the address so the pair never splits
  always_ff @(posedge mclk) begin
    if (rst) begin
      flash_wdata_ff <= 8'h0;
    end else if (req.valid && in_flash) begin
      flash_wdata_ff <= req.wdata;
    end
  end

  // pending info answer for the cycle after the request
  always_ff @(posedge mclk) begin
    if (rst) begin
      info_pend_ff <= 1'b0;
    end else begin
      info_pend_ff <= rd_info;
    end
  end

  // pending blank answer, no array access behind it
  always_ff @(posedge mclk) begin
    if (rst) begin
      blank_pend_ff <= 1'b0;
    end else begin
      blank_pend_ff <= rd_blank;
    end
  end

  // pending array answer, data arrives while flash_rd_ff stands
  always_ff @(posedge mclk) begin
    if (rst) begin
      flash_pend_ff <= 1'b0;
    end else begin
      flash_pend_ff <= rd_flash;
    end
  end

  // captured every cycle to keep the rom path one flop deep;
  // the pend flag alone decides whether the byte is ever used
  always_ff @(posedge mclk) begin
    if (rst) begin
      info_hold_ff <= 8'h0;
    end else begin
      info_hold_ff <= info_byte;
    end
  end

  // class of the last valid request, for observation only
  always_ff @(posedge mclk) begin
    if (rst) begin
      region_ff <= pmmo_region_vec;
    end else if (req.valid) begin
      region_ff <= nxt_region;
    end
  end

  // answer byte: info area, blank fill or what the array returned;
  // holds the last answer when nothing is pending
  always_comb begin
    nxt_rdata = rsp_ff.rdata;
    if (info_pend_ff) begin
      nxt_rdata = info_hold_ff; // RULE9 RULE10 RULE13
    end else if (blank_pend_ff) begin
      nxt_rdata = `PMMO_BLANK_BYTE; // RULE3 RULE14
    end else if (flash_pend_ff) begin
      nxt_rdata = flash_rdata; // RULE11
    end
  end

  // read answer two cycles after request, flash given one cycle to respond
  always_ff @(posedge mclk) begin
    if (rst) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= info_pend_ff || blank_pend_ff || flash_pend_ff;
      rsp_ff.rdata <= nxt_rdata;
    end
  end

  // data memory space has nothing behind it: never acknowledged;
  // the strobe is kept as a port so the core side needs no stub
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_space_ack_ff <= 1'b0;
    end else begin
      data_space_ack_ff <= 1'b0 & data_space_req; // RULE6
    end
  end
endmodule : pmmo_decoder

//--- sim/pmmo_decoder_sva.sv
// checker for the program memory overlay decoder
module pmmo_decoder_sva
  import pmmo_pkg::*;
#(parameter logic [15:0] FLASH_TOP = 16'hffff) (
  input wire logic mclk,
  input wire logic rst,
  input wire pmmo_req_t req,
  input wire logic [7:0] page_sel,
  input wire pmmo_rsp_t rsp_ff,
  input wire logic data_space_ack_ff,
  input wire logic [15:0] flash_addr_ff,
  input wire logic flash_rd_ff,
  input wire logic flash_wr_ff,
  input wire logic [7:0] flash_wdata_ff,
  input wire pmmo_region_t region_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic rd, ov, wr, hi;
  assign rd = req.valid && !req.wr;
  assign wr = req.valid && req.wr;
  assign hi = req.addr > FLASH_TOP;
  assign ov = page_sel[7] && req.addr >= 16'hfe00
              && req.src != pmmo_src_fetch;
  a_read_answered: assert property (rd |-> ##2 rsp_ff.valid)
    else $error("read not answered");
  a_blank_read: assert property (
    rd && hi && !ov |-> ##2 rsp_ff.rdata == 8'hff)
    else $error("blank read not ff");
  a_write_dropped: assert property (
    wr && hi |=> !flash_wr_ff)
    else $error("write above flash passed");
  a_write_passed: assert property (
    wr && !hi |=> flash_wr_ff && flash_addr_ff == $past(req.addr)
      && flash_wdata_ff == $past(req.wdata))
    else $error("flash write lost");
  a_fetch_flash: assert property (
    rd && req.src == pmmo_src_fetch && !hi |=> flash_rd_ff)
    else $error("fetch skipped flash");
  a_overlay_read: assert property (
    rd && ov |=> !flash_rd_ff ##1 rsp_ff.valid)
    else $error("overlay read went to flash");
  a_vector_region: assert property (
    req.valid && req.addr < 16'h0038 |=> region_ff == pmmo_region_vec)
    else $error("vector region wrong");
  a_no_data_ack: assert property (!data_space_ack_ff)
    else $error("data space answered");
  c_overlay: cover property (rd && ov);
  c_blank: cover property (rd && hi);
  c_write: cover property (flash_wr_ff);
endmodule : pmmo_decoder_sva

//--- sim/pmmo_flash_model.sv
// flash array stand-in behind the decoder
module pmmo_flash_model (
  input wire logic rd,
  input wire logic [15:0] addr,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // data only while read stands, else the inverse so stale reads show
  assign rdata = (addr[7:0] ^ addr[15:8] ^ 8'h5a) ^ {8{!rd}};
endmodule : pmmo_flash_model

//--- sim/test_pmmo_decoder.sv
// self-checking bench for the program memory overlay decoder
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module test_pmmo_decoder import pmmo_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, rst = 1, dsr = 0, fr, fw, ack;
  pmmo_req_t req = '0;
  pmmo_rsp_t rsp;
  logic [7:0] ps = 8'h00, frd;
  logic [15:0] fa;
  int errors = 0, checked = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  pmmo_decoder #(.FLASH_TOP(16'h3fff)) i_dut (.mclk, .rst, .req,
    .page_sel(ps), .data_space_req(dsr), .flash_rdata(frd), .rsp_ff(rsp),
    .data_space_ack_ff(ack), .flash_addr_ff(fa), .flash_rd_ff(fr),
    .flash_wr_ff(fw), .flash_wdata_ff(), .region_ff());
  pmmo_flash_model i_flash (.rd(fr), .addr(fa), .rdata(frd));
  function automatic logic [7:0] fl(logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : fl
  task automatic acc(pmmo_src_t s, logic w, logic [15:0] a);
    @(posedge mclk) req <= '{1'b1, w, s, a, 8'h3c};
    @(posedge mclk) req <= '0;
    @(posedge mclk);
    #1;
  endtask : acc
  task automatic wr(logic [15:0] a, logic e);
    @(posedge mclk) req <= '{1'b1, 1'b1, pmmo_src_load, a, 8'h3c};
    @(posedge mclk) req <= '0;
    #1;
    `CHK("flash_wr", e, fw)
    if (e) `CHK("flash_addr", a, fa)
    @(posedge mclk) #1;
  endtask : wr
  task automatic rd(pmmo_src_t s, logic [15:0] a, logic [7:0] e);
    acc(s, 1'b0, a);
    `CHK("valid", 1'b1, rsp.valid)
    `CHK("rdata", e, rsp.rdata)
  endtask : rd
  task automatic t_map;
    rd(pmmo_src_fetch, 16'h0002, fl(16'h0002));
    rd(pmmo_src_load, 16'h3fff, fl(16'h3fff));
    rd(pmmo_src_load, 16'h4000, 8'hff);
    rd(pmmo_src_dbg, 16'hffff, 8'hff);
  endtask : t_map
  task automatic t_ovl;
    @(posedge mclk) ps <= 8'h80;
    rd(pmmo_src_load, 16'hfe40, 8'h50);
    rd(pmmo_src_dbg, 16'hfe45, 8'h44);
    rd(pmmo_src_load, 16'hfe53, 8'h00);
    rd(pmmo_src_load, 16'hfe00, 8'hff);
    rd(pmmo_src_fetch, 16'hfe40, 8'hff);
    @(posedge mclk) ps <= 8'h00;
    rd(pmmo_src_load, 16'hfe40, 8'hff);
  endtask : t_ovl
  task automatic t_wr;
    @(posedge mclk) ps <= 8'h80;
    wr(16'hfe41, 1'b0);
    wr(16'h0010, 1'b1);
    rd(pmmo_src_load, 16'hfe41, 8'h41);
    @(posedge mclk) dsr <= 1'b1;
    @(posedge mclk) dsr <= 1'b0;
    @(posedge mclk) #1;
    `CHK("ack", 1'b0, ack)
  endtask : t_wr
  task automatic summarize;
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_map();
    t_ovl();
    t_wr();
    summarize();
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      summarize();
    end
  end
endmodule : test_pmmo_decoder
bind pmmo_decoder pmmo_decoder_sva #(.FLASH_TOP(FLASH_TOP)) i_sva (.mclk,
  .rst, .req, .page_sel, .rsp_ff, .data_space_ack_ff, .flash_addr_ff,
  .flash_rd_ff, .flash_wr_ff, .flash_wdata_ff, .region_ff);
